//--- rtl/estc_trigger_ctrl.sv
// Exposure start trigger control: free-run pacing, source select, exposure length
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Trigger off: generate start events from acquisition start until stop.
// - Free-run paces starts at the programmed frame period.
// - Programmed rate above maximum is clamped to the maximum rate.
// - Trigger off: exposure length comes from programmed exposure time.
// - Trigger on: one start per outside event, from selected source only.
// - Five sources: software, user bit, link, timer, external pin.
// - Polarity selects rising or falling edge as start event.
// - Software source always uses programmed exposure time.
// - Link/pin: timed uses exposure time, pulse width follows active phase.
// - Timer, pulse width, edge activation: length is timer duration.
// - Timer, pulse width, level activation: length follows held level.
// - User bit pulse width: exposure follows the user bit on/off.
// - Waiting with software source: software trigger starts exposure.
// - Start leaves waiting status; return once new start acceptable.
// - Software triggers while not ready are discarded.
// - Link source starts on selected link edge when waiting.
// - One frame per link trigger period.
// - Start events while not waiting are ignored.
// - No frame before acquisition start; stop ends acquisition ability.
//////////////////////////////////////////////////////////////////////////////
module estc_trigger_ctrl (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        coax_link_trigger_source_in,
    input  wire logic        timer_pulse_source_in,
    input  wire logic        external_input_pin_source_in,
    output logic             exposing_out,
    output logic             exp_start_out,
    output logic             waiting_out,
    output logic             acq_active_out
);
    import estc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXP  = 3'b010,
        ST_BUSY = 3'b100
    } estc_state_e;

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [4:0]  ctrl_q;
    logic [2:0]  src_q;
    logic [31:0] period_q;
    logic [31:0] minper_q;
    logic [31:0] exptime_q;
    logic [31:0] tmrdur_q;
    logic [31:0] ready_q;
    logic [31:0] rdata_q;
    logic        acq_q;
    logic        sw_trig_q;

    wire wr_ctrl_w   = wr_in && (addr_in == OFS_CTRL);
    wire wr_src_w    = wr_in && (addr_in == OFS_SRC);
    wire wr_per_w    = wr_in && (addr_in == OFS_PERIOD);
    wire wr_minper_w = wr_in && (addr_in == OFS_MINPER);
    wire wr_exp_w    = wr_in && (addr_in == OFS_EXPTIME);
    wire wr_tmr_w    = wr_in && (addr_in == OFS_TMRDUR);
    wire wr_cmd_w    = wr_in && (addr_in == OFS_CMD);
    wire wr_ready_w  = wr_in && (addr_in == OFS_READY);
    wire cmd_start_w = wr_cmd_w && wdata_in[CMD_ACQ_START];
    wire cmd_stop_w  = wr_cmd_w && wdata_in[CMD_ACQ_STOP];
    wire cmd_sw_w    = wr_cmd_w && wdata_in[CMD_SW_TRIG];

    wire trig_on_w   = ctrl_q[CTRL_TRIG_ON];
    wire rising_w    = ctrl_q[CTRL_RISING];
    wire pwidth_w    = ctrl_q[CTRL_PWIDTH];
    wire tmr_level_w = ctrl_q[CTRL_TMR_LEVEL];
    wire user_bit_w  = ctrl_q[CTRL_USER_BIT];

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q    <= '0;
            src_q     <= SRC_SOFTWARE;
            period_q  <= RST_PERIOD;
            minper_q  <= RST_MINPER;
            exptime_q <= RST_EXPTIME;
            tmrdur_q  <= RST_TMRDUR;
            ready_q   <= RST_READY;
        end else begin
            if (wr_ctrl_w)   ctrl_q    <= wdata_in[4:0];
            if (wr_src_w)    src_q     <= wdata_in[2:0];
            if (wr_per_w)    period_q  <= wdata_in;
            if (wr_minper_w) minper_q  <= wdata_in;
            if (wr_exp_w)    exptime_q <= wdata_in;
            if (wr_tmr_w)    tmrdur_q  <= wdata_in;
            if (wr_ready_w)  ready_q   <= wdata_in;
        end
    end

    // Acquisition enable; stop takes priority over a simultaneous start
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            acq_q     <= 1'b0;
            sw_trig_q <= 1'b0;
        end else begin
            acq_q     <= cmd_stop_w ? 1'b0 : (cmd_start_w ? 1'b1 : acq_q);
            sw_trig_q <= cmd_sw_w;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Source synchronisers and edge detection
    logic [2:0] pins_w;
    logic [2:0] pins_prev_q;
    logic       user_prev_q;

    estc_sync #(.WIDTH(3)) u_sync (
        .mclk_in   (mclk_in),
        .rst_in    (rst_in),
        .async_in  ({external_input_pin_source_in, timer_pulse_source_in,
                     coax_link_trigger_source_in}),
        .level_out (pins_w)
    );

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pins_prev_q <= '0;
            user_prev_q <= 1'b0;
        end else begin
            pins_prev_q <= pins_w;
            user_prev_q <= user_bit_w;
        end
    end

    // Selected source level and its previous value
    wire sel_lvl_w  = (src_q == SRC_USER_BIT) ? user_bit_w :
                      (src_q == SRC_LINK)     ? pins_w[0]  :
                      (src_q == SRC_TIMER)    ? pins_w[1]  :
                      (src_q == SRC_EXT_PIN)  ? pins_w[2]  : 1'b0;
    wire sel_prev_w = (src_q == SRC_USER_BIT) ? user_prev_q    :
                      (src_q == SRC_LINK)     ? pins_prev_q[0] :
                      (src_q == SRC_TIMER)    ? pins_prev_q[1] :
                      (src_q == SRC_EXT_PIN)  ? pins_prev_q[2] : 1'b0;
    // Active phase is high for rising, low for falling
    wire act_now_w  = rising_w ? sel_lvl_w : ~sel_lvl_w;
    wire act_prev_w = rising_w ? sel_prev_w : ~sel_prev_w;
    wire hw_edge_w  = act_now_w && !act_prev_w;
    wire ext_event_w = (src_q == SRC_SOFTWARE) ? sw_trig_q : hw_edge_w;

    //////////////////////////////////////////////////////////////////////////
    // Free-run pacing
    logic [31:0] frc_q;
    wire  [31:0] eff_per_w = (period_q < minper_q) ? minper_q : period_q;
    wire         frc_hit_w = (frc_q == 32'h0000_0000);
    wire         free_run_w = acq_q && !trig_on_w;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            frc_q <= '0;
        end else if (!free_run_w) begin
            frc_q <= '0;
        end else if (frc_hit_w) begin
            frc_q <= eff_per_w - 32'h0000_0001;
        end else begin
            frc_q <= frc_q - 32'h0000_0001;
        end
    end

    wire start_req_w = trig_on_w ? ext_event_w : (free_run_w && frc_hit_w);

    //////////////////////////////////////////////////////////////////////////
    // Exposure length selection
    wire sw_src_w    = (src_q == SRC_SOFTWARE);
    wire use_width_w = trig_on_w && !sw_src_w && pwidth_w &&
                       !((src_q == SRC_TIMER) && !tmr_level_w);
    wire use_tmr_w   = trig_on_w && (src_q == SRC_TIMER) && pwidth_w &&
                       !tmr_level_w;
    wire [31:0] len_w = use_tmr_w ? tmrdur_q : exptime_q;

    //////////////////////////////////////////////////////////////////////////
    // Exposure state machine
    estc_state_e st_q;
    estc_state_e st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        width_q;
    logic        exp_start_q;

    wire accept_w = (st_q == ST_IDLE) && acq_q && start_req_w;
    wire cnt_done_w = (cnt_q <= 32'h0000_0001);
    wire exp_end_w  = width_q ? !act_now_w : cnt_done_w;

    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_IDLE: begin
                if (accept_w) begin
                    st_d  = ST_EXP;
                    cnt_d = len_w;
                end
            end
            ST_EXP: begin
                cnt_d = cnt_q - 32'h0000_0001;
                if (exp_end_w) begin
                    st_d  = ST_BUSY;
                    cnt_d = ready_q;
                end
            end
            ST_BUSY: begin
                cnt_d = cnt_q - 32'h0000_0001;
                if (cnt_done_w) st_d = ST_IDLE;
            end
            default: begin
                st_d  = ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q        <= ST_IDLE;
            cnt_q       <= '0;
            width_q     <= 1'b0;
            exp_start_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            width_q     <= accept_w ? use_width_w : width_q;
            exp_start_q <= accept_w;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read data and outputs
    logic exposing_q;
    logic waiting_q;
    logic acq_out_q;
    wire [31:0] status_w = {26'h0, src_q == SRC_SOFTWARE, width_q, st_q == ST_BUSY,
                            st_q == ST_EXP, st_q == ST_IDLE, acq_q};
    wire [31:0] rmux_w =
        (addr_in == OFS_CTRL)    ? {27'h0, ctrl_q} :
        (addr_in == OFS_SRC)     ? {29'h0, src_q}  :
        (addr_in == OFS_PERIOD)  ? period_q  :
        (addr_in == OFS_MINPER)  ? minper_q  :
        (addr_in == OFS_EXPTIME) ? exptime_q :
        (addr_in == OFS_TMRDUR)  ? tmrdur_q  :
        (addr_in == OFS_STATUS)  ? status_w  :
        (addr_in == OFS_READY)   ? ready_q   : 32'h0000_0000;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q    <= '0;
            exposing_q <= 1'b0;
            waiting_q  <= 1'b0;
            acq_out_q  <= 1'b0;
        end else begin
            rdata_q    <= rd_in ? rmux_w : 32'h0000_0000;
            exposing_q <= (st_d == ST_EXP);
            waiting_q  <= (st_d == ST_IDLE) && acq_q;
            acq_out_q  <= acq_q;
        end
    end

    assign rdata_out      = rdata_q;
    assign exposing_out   = exposing_q;
    assign exp_start_out  = exp_start_q;
    assign waiting_out    = waiting_q;
    assign acq_active_out = acq_out_q;

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    chk_no_acq_start: assert property (@(posedge mclk_in) disable iff (rst_in)
        !acq_q |-> !accept_w) else $error("start accepted without acquisition");
    chk_busy_ignore: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q != ST_IDLE) |=> !exp_start_q) else $error("start while busy");
    chk_start_exp: assert property (@(posedge mclk_in) disable iff (rst_in)
        accept_w |=> exposing_q && !waiting_q) else $error("start not exposing");
    chk_sw_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
        sw_trig_q |=> !sw_trig_q) else $error("software trigger pulse too long");
    chk_free_gap: assert property (@(posedge mclk_in) disable iff (rst_in)
        (free_run_w && frc_hit_w) |=> (frc_q == eff_per_w - 32'h0000_0001) || !free_run_w)
        else $error("free-run period wrong");
    chk_clamp: assert property (@(posedge mclk_in) disable iff (rst_in)
        eff_per_w >= minper_q) else $error("period not clamped");
    chk_sw_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (accept_w && sw_src_w) |=> (cnt_q == exptime_q) && !width_q)
        else $error("software length wrong");
    chk_tmr_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (accept_w && use_tmr_w) |=> (cnt_q == tmrdur_q)) else $error("timer length wrong");
    chk_off_len: assert property (@(posedge mclk_in) disable iff (rst_in)
        (accept_w && !trig_on_w) |=> !width_q) else $error("free-run uses width");
    chk_width_end: assert property (@(posedge mclk_in) disable iff (rst_in)
        (st_q == ST_EXP && width_q && !act_now_w) |=> (st_q == ST_BUSY))
        else $error("width exposure did not end");
    chk_edge_only: assert property (@(posedge mclk_in) disable iff (rst_in)
        (accept_w && trig_on_w && !sw_src_w) |-> act_now_w && !act_prev_w)
        else $error("start without chosen edge");

    // Exposure end hands over to the busy phase, not straight to waiting
    sequence s_exp_leave;
        (st_q == ST_EXP) && exp_end_w;
    endsequence
    sequence s_busy_hold;
        (st_q == ST_BUSY) && !waiting_q && !exposing_q;
    endsequence
    chk_exp_to_busy: assert property (@(posedge mclk_in) disable iff (rst_in)
        s_exp_leave |=> s_busy_hold) else $error("exposure did not hand over to busy");
endmodule : estc_trigger_ctrl

//--- rtl/estc_pkg.sv
// Package for the exposure start trigger control block
package estc_pkg;
    // Trigger source selector codes
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_USER_BIT = 3'h1;
    localparam logic [2:0] SRC_LINK     = 3'h2;
    localparam logic [2:0] SRC_TIMER    = 3'h3;
    localparam logic [2:0] SRC_EXT_PIN  = 3'h4;
    // Register word offsets
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_SRC      = 4'h1;
    localparam logic [3:0] OFS_PERIOD   = 4'h2;
    localparam logic [3:0] OFS_MINPER   = 4'h3;
    localparam logic [3:0] OFS_EXPTIME  = 4'h4;
    localparam logic [3:0] OFS_TMRDUR   = 4'h5;
    localparam logic [3:0] OFS_CMD      = 4'h6;
    localparam logic [3:0] OFS_STATUS   = 4'h7;
    localparam logic [3:0] OFS_READY    = 4'h8;
    // CTRL field positions
    localparam int CTRL_TRIG_ON   = 0;
    localparam int CTRL_RISING    = 1;
    localparam int CTRL_PWIDTH    = 2;
    localparam int CTRL_TMR_LEVEL = 3;
    localparam int CTRL_USER_BIT  = 4;
    // CMD field positions (write one to issue)
    localparam int CMD_ACQ_START = 0;
    localparam int CMD_ACQ_STOP  = 1;
    localparam int CMD_SW_TRIG   = 2;
    // Reset values
    localparam logic [31:0] RST_PERIOD  = 32'h0000_0100;
    localparam logic [31:0] RST_MINPER  = 32'h0000_0040;
    localparam logic [31:0] RST_EXPTIME = 32'h0000_0010;
    localparam logic [31:0] RST_TMRDUR  = 32'h0000_0010;
    localparam logic [31:0] RST_READY   = 32'h0000_0008;
    // Synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 3;
endpackage : estc_pkg

//--- rtl/estc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module estc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             mclk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level_out
);
    import estc_pkg::*;
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] lvl_q;
    wire  [WIDTH-1:0] agree_w = ~(s2_q ^ s3_q);
    wire  [WIDTH-1:0] lvl_d   = (agree_w & s2_q) | (~agree_w & lvl_q);

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end
    assign level_out = lvl_q;
endmodule : estc_sync

//--- tb/estc_src_model.sv
// Far-side trigger source model: link, timer and external pin levels
`timescale 1ns/10ps
module estc_src_model (
    input  wire logic       mclk_in,
    output logic      [2:0] pins_out
);
    initial pins_out = 3'h0;

    // One clean pulse per wanted frame; the idle level is the inactive phase
    task pulse(input int idx, input logic act, input int w);
        @(posedge mclk_in);
        pins_out[idx] <= ~act;
        repeat (6) @(posedge mclk_in);
        pins_out[idx] <= act;
        repeat (w) @(posedge mclk_in);
        pins_out[idx] <= ~act;
        repeat (6) @(posedge mclk_in);
    endtask : pulse
endmodule : estc_src_model

//--- tb/estc_trigger_ctrl_tb.sv
// Self-checking bench for the exposure start trigger control block
`timescale 1ns/10ps
module estc_trigger_ctrl_tb;
    import estc_pkg::*;
    typedef struct {logic [4:0] ctrl; logic [2:0] src; int w; int e; int t;} estc_row_s;
    logic        mclk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  addr_in = 4'h0;
    logic [31:0] wdata_in = 32'h0;
    logic        wr_in = 1'b0;
    logic        rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic [2:0]  pins;
    logic        exposing_out, exp_start_out, waiting_out, acq_active_out;
    logic [31:0] v;
    int          n_fail = 0, check_count = 0, n_st = 0, since = 0, gap = 0, run = 0, len = 0;
    int          s0;
    logic [3:0]  ra [6] = '{OFS_PERIOD, OFS_MINPER, OFS_EXPTIME, OFS_TMRDUR, OFS_READY, 4'hf};
    logic [31:0] rv [6] = '{RST_PERIOD, RST_MINPER, RST_EXPTIME, RST_TMRDUR, RST_READY, 32'h0};
    // ctrl, source, pulse width, expected exposure length, tolerance
    estc_row_s   rows [9] = '{
        '{5'h07, SRC_SOFTWARE, 0, 16, 0},
        '{5'h07, SRC_LINK, 12, 12, 1},
        '{5'h01, SRC_LINK, 5, 16, 0},
        '{5'h07, SRC_TIMER, 3, 16, 0},
        '{5'h0f, SRC_TIMER, 20, 20, 1},
        '{5'h05, SRC_EXT_PIN, 9, 9, 1},
        '{5'h03, SRC_EXT_PIN, 4, 16, 0},
        '{5'h07, SRC_USER_BIT, 10, 10, 1},
        '{5'h03, SRC_USER_BIT, 4, 16, 0}};

    always #20 mclk_in = ~mclk_in;

    estc_trigger_ctrl i_dut (
        .mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .coax_link_trigger_source_in(pins[0]), .timer_pulse_source_in(pins[1]),
        .external_input_pin_source_in(pins[2]), .exposing_out(exposing_out),
        .exp_start_out(exp_start_out), .waiting_out(waiting_out),
        .acq_active_out(acq_active_out));

    estc_src_model i_src (.mclk_in(mclk_in), .pins_out(pins));

    // Start count, start spacing and last exposure length
    always @(posedge mclk_in) begin
        if (exp_start_out === 1'b1) begin
            gap <= since;
            since <= 1;
            n_st <= n_st + 1;
        end else begin
            since <= since + 1;
        end
        if (exposing_out === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            len <= run;
            run <= 0;
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic chk_rng(input string nm, input int e, input int t, input int g);
        check_count++;
        if (g < e - t || g > e + t) begin
            n_fail++;
            $display("Error %s expected %0d seen %0d", nm, e, g);
        end
    endtask : chk_rng

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
    endtask : rd

    task automatic wait_starts(input int k);
        int i;
        int tgt;
        i = 0;
        tgt = n_st + k;
        while (n_st < tgt && i < 1000) begin
            @(posedge mclk_in);
            i++;
        end
        if (i >= 1000) begin
            n_fail++;
            $display("Error start count expected %0d seen %0d", tgt, n_st);
            finish_test();
        end
    endtask : wait_starts

    task automatic wait_idle();
        int i;
        i = 0;
        while (waiting_out !== 1'b1 && i < 400) begin
            @(posedge mclk_in);
            i++;
        end
        if (i >= 400) begin
            n_fail++;
            $display("Error waiting_out expected 1 seen %b", waiting_out);
            finish_test();
        end
    endtask : wait_idle

    initial begin
        repeat (3) @(posedge mclk_in);
        chk("outputs in reset", 32'h0, {exposing_out, exp_start_out, waiting_out, acq_active_out});
        rst_in <= 1'b0;
        foreach (ra[k]) begin
            rd(ra[k], v);
            chk("reset value", rv[k], v);
        end
        wr(OFS_CMD, 32'h4);
        repeat (30) @(posedge mclk_in);
        chk("starts before acquisition", 32'h0, n_st);
        // Trigger mode on first, so acquisition start does not free-run
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CMD, 32'h1);
        repeat (2) @(posedge mclk_in);
        chk("acq and waiting", 32'h3, {acq_active_out, waiting_out});
        ////////////////////////////////////////////////////////////////////////
        foreach (rows[k]) begin
            wr(OFS_SRC, {29'h0, rows[k].src});
            wr(OFS_CTRL, {27'h0, rows[k].ctrl});
            s0 = n_st;
            if (rows[k].src == SRC_SOFTWARE) begin
                wr(OFS_CMD, 32'h4);
            end else if (rows[k].src == SRC_USER_BIT) begin
                wr(OFS_CTRL, 32'h10 | rows[k].ctrl);
                repeat (rows[k].w - 2) @(posedge mclk_in);
                wr(OFS_CTRL, {27'h0, rows[k].ctrl});
            end else begin
                i_src.pulse(rows[k].src - SRC_LINK, rows[k].ctrl[1], rows[k].w);
            end
            repeat (4) @(posedge mclk_in);
            wait_idle();
            chk("starts per trigger", s0 + 1, n_st);
            chk_rng("exposure length", rows[k].e, rows[k].t, len);
        end
        ////////////////////////////////////////////////////////////////////////
        wr(OFS_SRC, 32'h0);
        wr(OFS_CTRL, 32'h3);
        s0 = n_st;
        wr(OFS_CMD, 32'h4);
        repeat (3) @(posedge mclk_in);
        chk("exposing and waiting", 32'h2, {exposing_out, waiting_out});
        rd(OFS_STATUS, v);
        chk("status while exposing", 32'h25, v);
        wr(OFS_CMD, 32'h4);
        i_src.pulse(0, 1'b1, 3);
        wait_idle();
        chk("starts while busy", s0 + 1, n_st);
        wr(OFS_SRC, 32'h2);
        wr(OFS_CTRL, 32'h3);
        s0 = n_st;
        for (int k = 0; k < 3; k++) begin
            i_src.pulse(0, 1'b1, 2);
            repeat (20) @(posedge mclk_in);
        end
        chk("link starts", s0 + 3, n_st);
        ////////////////////////////////////////////////////////////////////////
        wr(OFS_PERIOD, 32'h60);
        wr(OFS_CTRL, 32'h4);
        wait_starts(3);
        chk("free-run period", 32'h60, gap);
        chk_rng("free-run exposure", 16, 0, len);
        wr(OFS_PERIOD, 32'h30);
        wait_starts(3);
        chk("clamped period", RST_MINPER, gap);
        wr(OFS_CMD, 32'h2);
        repeat (40) @(posedge mclk_in);
        s0 = n_st;
        chk("acq_active_out", 32'h0, acq_active_out);
        repeat (200) @(posedge mclk_in);
        chk("starts after stop", s0, n_st);
        ////////////////////////////////////////////////////////////////////////
        // Reset in mid-run while free-running
        wr(OFS_CMD, 32'h1);
        repeat (30) @(posedge mclk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        chk("outputs in mid reset", 32'h0, {exposing_out, exp_start_out, waiting_out, acq_active_out});
        rst_in <= 1'b0;
        s0 = n_st;
        rd(OFS_PERIOD, v);
        chk("period after reset", RST_PERIOD, v);
        repeat (100) @(posedge mclk_in);
        chk("starts after reset", s0, n_st);
        chk("acq after reset", 32'h0, {acq_active_out, waiting_out});
        finish_test();
    end
endmodule : estc_trigger_ctrl_tb
